// File: ods_debounce.sv
`timescale 1ns/100ps
module ods_debounce (
  // Clock and reset.
  input  wire logic      sys_clk,
  input  wire logic      rst_b,
  input  wire logic      clk_en,
  // Control.
  input  wire logic      tick,
  input  wire logic      run,
  input  wire logic      restart,
  input  wire logic      dec_mode,
  input  wire logic [7:0] db_limit,
  input  wire logic      freeze,
  // Candidate and result.
  input  wire ods_pkg::ods_pose_t cand,
  output ods_pkg::ods_pose_t      candidate_r,
  output logic           accept
);

  import ods_pkg::*;

  logic [7:0] cnt_r;
  logic [7:0] cnt_nxt;
  ods_pose_t  cand_nxt;

  always_comb begin
    cnt_nxt  = cnt_r;
    cand_nxt = candidate_r;
    accept   = 1'b0;
    if (restart) begin
      cnt_nxt = ODS_DB_ZERO;
    end else if (run && tick && !freeze) begin
      if (cand != candidate_r) begin
        cand_nxt = cand;
        if (dec_mode) begin
          cnt_nxt = (cnt_r == ODS_DB_ZERO) ? ODS_DB_ZERO : cnt_r - ODS_DB_ONE;
        end else begin
          cnt_nxt = ODS_DB_ZERO;
        end
      end else if (cnt_r < db_limit) begin
        cnt_nxt = cnt_r + ODS_DB_ONE;
      end
      // Accept once the candidate holds and the count reaches db_limit; in dec_mode a change only steps the count down.
      accept = (cand == candidate_r) && (cnt_nxt >= db_limit);
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r       <= ODS_DB_ZERO;
      candidate_r <= ODS_POSE_RST;
    end else if (clk_en) begin
      cnt_r       <= cnt_nxt;
      candidate_r <= cand_nxt;
    end
  end

endmodule : ods_debounce

// File: ods_host.sv
`timescale 1ns/100ps
module ods_host (
  // Clock.
  input  wire logic        sys_clk,
  // Register access.
  output ods_pkg::ods_bus_t bus,
  input  wire logic [7:0]  rdata_r
);
  import ods_pkg::*;

  initial bus = '0;

  // A released bus drops rd and wr and shows inverted addr and wdata so stale values never pass as valid.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge sys_clk);
    #1 bus = '{rd: !w, wr: w, addr: a, wdata: d};
    @(posedge sys_clk);
    #1 bus = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
    q = rdata_r;
  endtask : xfer
endmodule : ods_host

// File: ods_pkg.sv
package ods_pkg;

  localparam logic [7:0] ODS_ADDR_STATUS  = 8'h28;
  localparam logic [7:0] ODS_ADDR_SETUP   = 8'h29;
  localparam logic [7:0] ODS_ADDR_DBCOUNT = 8'h2A;

  localparam logic [7:0] ODS_STATUS_RST  = 8'h00;
  localparam logic [7:0] ODS_SETUP_RST   = 8'h80;
  localparam logic [7:0] ODS_DBCOUNT_RST = 8'h00;

  localparam int ODS_BIT_CHANGE = 7;
  localparam int ODS_BIT_LOCK   = 6;
  localparam int ODS_BIT_UPHI   = 2;
  localparam int ODS_BIT_UPLO   = 1;
  localparam int ODS_BIT_FACE   = 0;
  localparam int ODS_BIT_DBMODE = 7;
  localparam int ODS_BIT_EN     = 6;

  localparam logic [1:0] ODS_UP_PORTRAIT_UP   = 2'h0;
  localparam logic [1:0] ODS_UP_PORTRAIT_DOWN = 2'h1;
  localparam logic [1:0] ODS_UP_LAND_RIGHT    = 2'h2;
  localparam logic [1:0] ODS_UP_LAND_LEFT     = 2'h3;

  localparam logic       ODS_FACE_FRONT = 1'b0;
  localparam logic       ODS_FACE_BACK  = 1'b1;

  localparam logic [7:0] ODS_DB_ZERO = 8'h00;
  localparam logic [7:0] ODS_DB_ONE  = 8'h01;

  typedef struct packed {
    logic       lockout;
    logic [1:0] upright;
    logic       face;
  } ods_pose_t;

  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ods_bus_t;

  localparam ods_pose_t ODS_POSE_RST = '{lockout: 1'b0, upright: ODS_UP_PORTRAIT_UP, face: ODS_FACE_FRONT};

endpackage : ods_pkg

// File: ods_status.sv
`timescale 1ns/100ps
module ods_status (
  // Clock, reset, enable.
  input  wire logic      sys_clk,
  input  wire logic      rst_b,
  input  wire logic      clk_en,
  // Register access from the serial host interface.
  input  ods_pkg::ods_bus_t bus,
  output logic [7:0]     rdata_r,
  // Sensor side.
  input  wire logic      odr_tick,
  input  wire ods_pkg::ods_pose_t raw_pose,
  input  wire logic      over_range,
  input  wire logic      active_mode,
  input  wire logic      trig_mode,
  input  wire logic      wake_mode,
  input  wire logic      soft_reset,
  input  wire logic [7:0] debounce_count_value,
  // Outputs to the rest of the device.
  output logic           pose_change_flag,
  output logic           pose_irq_source,
  output logic           aslp_timer_clr,
  output logic           pose_detect_en
);

  import ods_pkg::*;

  // Pose result group.
  ods_pose_t  pose_r;
  ods_pose_t  pose_nxt;
  logic       first_r;
  logic       first_nxt;
  // Change flag group.
  logic       flag_r;
  logic       flag_nxt;
  // Setup register group.
  logic       setup_dbm_r;
  logic       setup_dbm_nxt;
  logic       setup_en_r;
  logic       setup_en_nxt;
  // Read data group.
  logic [7:0] rdata_nxt;
  // Edge history group.
  logic       run_prev_r;
  logic       run_prev_nxt;
  logic       wake_prev_r;
  logic       wake_prev_nxt;
  logic       flag_prev_r;
  logic       flag_prev_nxt;
  // Decoded strobes and debounce hand-off.
  logic       run_now;
  logic       go_active;
  logic       restart;
  logic       accept;
  logic       set_evt;
  logic       rd_status;
  logic       wr_setup;
  ods_pose_t  cand_r;

  // True when the bus presents the given kind of access to the given address.
  function automatic logic bus_hit(input ods_bus_t b, input logic is_wr, input logic [7:0] addr);
    return (is_wr ? b.wr : b.rd) && (b.addr == addr);
  endfunction : bus_hit

  // Packs the change flag and the pose fields into the status byte; reserved bits read zero.
  function automatic logic [7:0] pack_status(input logic flag, input ods_pose_t p);
    logic [7:0] byte_v;
    byte_v                            = ODS_STATUS_RST;
    byte_v[ODS_BIT_CHANGE]            = flag;
    byte_v[ODS_BIT_LOCK]              = p.lockout;
    byte_v[ODS_BIT_UPHI:ODS_BIT_UPLO] = p.upright;
    byte_v[ODS_BIT_FACE]              = p.face;
    return byte_v;
  endfunction : pack_status

  // Packs the setup fields; the unused bits read zero.
  function automatic logic [7:0] pack_setup(input logic dbm, input logic en);
    logic [7:0] byte_v;
    byte_v                 = '0;
    byte_v[ODS_BIT_DBMODE] = dbm;
    byte_v[ODS_BIT_EN]     = en;
    return byte_v;
  endfunction : pack_setup

  assign run_now   = active_mode | trig_mode;
  assign go_active = run_now & ~run_prev_r;
  // Any run-state or wake/sleep change restarts the debounce.
  assign restart   = (run_now ^ run_prev_r) | (wake_mode ^ wake_prev_r) | soft_reset;
  assign rd_status = bus_hit(bus, 1'b0, ODS_ADDR_STATUS);
  assign wr_setup  = bus_hit(bus, 1'b1, ODS_ADDR_SETUP);

  ods_debounce u_deb (
    .sys_clk     (sys_clk),
    .rst_b       (rst_b),
    .clk_en      (clk_en),
    .tick        (odr_tick),
    .run         (run_now & setup_en_r),
    .restart     (restart),
    .dec_mode    (~setup_dbm_r),
    .db_limit    (debounce_count_value),
    .freeze      (over_range),
    .cand        (raw_pose),
    .candidate_r (cand_r),
    .accept      (accept)
  );

  always_comb begin
    pose_nxt  = pose_r;
    first_nxt = first_r;
    set_evt   = 1'b0;
    if (go_active || soft_reset) begin
      pose_nxt  = ODS_POSE_RST;
      first_nxt = ~soft_reset;
    end else if (accept) begin
      // Fields track live even when the flag is already pending.
      pose_nxt  = cand_r;
      first_nxt = 1'b0;
      set_evt   = first_r || (cand_r != pose_r);
    end
    if (!run_now) begin
      first_nxt = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pose_r  <= ODS_POSE_RST;
      first_r <= 1'b0;
    end else if (clk_en) begin
      pose_r  <= pose_nxt;
      first_r <= first_nxt;
    end
  end

  always_comb begin
    setup_dbm_nxt = setup_dbm_r;
    setup_en_nxt  = setup_en_r;
    if (wr_setup) begin
      setup_dbm_nxt = bus.wdata[ODS_BIT_DBMODE];
      setup_en_nxt  = bus.wdata[ODS_BIT_EN];
    end
    if (soft_reset) begin
      setup_dbm_nxt = ODS_SETUP_RST[ODS_BIT_DBMODE];
      setup_en_nxt  = ODS_SETUP_RST[ODS_BIT_EN];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      setup_dbm_r <= ODS_SETUP_RST[ODS_BIT_DBMODE];
      setup_en_r  <= ODS_SETUP_RST[ODS_BIT_EN];
    end else if (clk_en) begin
      setup_dbm_r <= setup_dbm_nxt;
      setup_en_r  <= setup_en_nxt;
    end
  end

  always_comb begin
    flag_nxt = flag_r;
    if (rd_status || soft_reset) begin
      flag_nxt = 1'b0;
    end
    // A new event wins over a clearing read in the same cycle.
    if (set_evt) begin
      flag_nxt = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      flag_r <= ODS_STATUS_RST[ODS_BIT_CHANGE];
    end else if (clk_en) begin
      flag_r <= flag_nxt;
    end
  end

  always_comb begin
    rdata_nxt = rdata_r;
    if (bus.rd) begin
      unique case (bus.addr)
        ODS_ADDR_STATUS: rdata_nxt = pack_status(flag_r, pose_r);
        ODS_ADDR_SETUP:  rdata_nxt = pack_setup(setup_dbm_r, setup_en_r);
        default:         rdata_nxt = '0;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_r <= '0;
    end else if (clk_en) begin
      rdata_r <= rdata_nxt;
    end
  end

  always_comb begin
    run_prev_nxt  = run_now;
    wake_prev_nxt = wake_mode;
    flag_prev_nxt = flag_r;
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      run_prev_r  <= 1'b0;
      wake_prev_r <= 1'b0;
      flag_prev_r <= 1'b0;
    end else if (clk_en) begin
      run_prev_r  <= run_prev_nxt;
      wake_prev_r <= wake_prev_nxt;
      flag_prev_r <= flag_prev_nxt;
    end
  end

  assign pose_change_flag = flag_r;
  assign pose_irq_source  = flag_r;
  assign aslp_timer_clr   = clk_en & flag_r & ~flag_prev_r;
  assign pose_detect_en   = setup_en_r;

endmodule : ods_status

// File: ods_status_asserts.sv
`timescale 1ns/100ps
module ods_status_asserts (
  // Clock and control.
  input wire logic              sys_clk,
  input wire logic              rst_b,
  input wire logic              clk_en,
  input wire logic              odr_tick,
  input wire logic              over_range,
  input wire logic              soft_reset,
  // Register bus.
  input wire ods_pkg::ods_bus_t bus,
  input wire logic [7:0]        rdata_r,
  // Results.
  input wire logic              pose_change_flag,
  input wire logic              pose_irq_source,
  input wire logic              aslp_timer_clr,
  input wire logic              pose_detect_en
);
  import ods_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  sequence s_rd(logic [7:0] a); clk_en && bus.rd && bus.addr == a; endsequence
  sequence s_quiet; !odr_tick && !$past(odr_tick); endsequence

  property p_irq; pose_irq_source == pose_change_flag; endproperty
  property p_clr; $rose(pose_change_flag) |-> ##[0:1] aslp_timer_clr; endproperty
  property p_stat; s_rd(ODS_ADDR_STATUS) |=> rdata_r[7] == $past(pose_change_flag) && rdata_r[5:3] == 3'h0;
  endproperty
  property p_rdclr; s_rd(ODS_ADDR_STATUS) ##0 s_quiet |=> !pose_change_flag; endproperty
  property p_setup; s_rd(ODS_ADDR_SETUP) |=> rdata_r[6] == $past(pose_detect_en) && rdata_r[5:0] == 6'h00;
  endproperty
  property p_wren; clk_en && bus.wr && bus.addr == ODS_ADDR_SETUP && !soft_reset |=> pose_detect_en == $past(bus.wdata[6]);
  endproperty
  property p_off; !pose_detect_en [*2] |=> !$rose(pose_change_flag); endproperty
  property p_over; over_range [*2] |=> !$rose(pose_change_flag); endproperty
  property p_srst; soft_reset && clk_en |=> !pose_change_flag && !pose_detect_en; endproperty

  a_irq: assert property (p_irq) else $error("irq source differs from flag");
  a_clr: assert property (p_clr) else $error("no timer clear on flag rise");
  a_stat: assert property (p_stat) else $error("bad status read data");
  a_rdclr: assert property (p_rdclr) else $error("status read did not clear flag");
  a_setup: assert property (p_setup) else $error("bad setup read data");
  a_wren: assert property (p_wren) else $error("enable write lost");
  a_off: assert property (p_off) else $error("flag rose while disabled");
  a_over: assert property (p_over) else $error("flag rose over range");
  a_srst: assert property (p_srst) else $error("soft reset left state");
endmodule : ods_status_asserts

bind ods_status ods_status_asserts i_chk (.sys_clk(sys_clk), .rst_b(rst_b), .clk_en(clk_en), .odr_tick(odr_tick),
  .over_range(over_range), .soft_reset(soft_reset), .bus(bus), .rdata_r(rdata_r), .pose_change_flag(pose_change_flag),
  .pose_irq_source(pose_irq_source), .aslp_timer_clr(aslp_timer_clr), .pose_detect_en(pose_detect_en));

// File: test_ods_status.sv
`timescale 1ns/100ps
module test_ods_status;
  import ods_pkg::*;
  logic       sys_clk, rst_b, odr_tick, over_range, active_mode, soft_reset, flag_m;
  logic       flag_o, irq_o, tclr_o, en_o, en_m, ce, trig;
  logic [7:0] rdata_r, dbc, q;
  ods_bus_t   bus;
  ods_pose_t  raw_pose, pose_m;
  int         err_total, comparisons, cycles, rises, clr_seen;

  ods_host i_host (.sys_clk(sys_clk), .bus(bus), .rdata_r(rdata_r));
  ods_status i_dut (.sys_clk(sys_clk), .rst_b(rst_b), .clk_en(ce), .bus(bus), .rdata_r(rdata_r),
    .odr_tick(odr_tick), .raw_pose(raw_pose), .over_range(over_range), .active_mode(active_mode),
    .trig_mode(trig), .wake_mode(1'b0), .soft_reset(soft_reset), .debounce_count_value(dbc),
    .pose_change_flag(flag_o), .pose_irq_source(irq_o), .aslp_timer_clr(tclr_o), .pose_detect_en(en_o));

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : summarize

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    i_host.xfer(w, a, d, q);
    if (w && a == ODS_ADDR_SETUP) en_m = d[ODS_BIT_EN];
    if (!w) check(q, d);
  endtask : acc

  task automatic rds();
    check(8'({flag_o, irq_o}), 8'({flag_m, flag_m}));
    check(8'(en_o), 8'(en_m));
    acc(1'b0, ODS_ADDR_STATUS, {flag_m, pose_m.lockout, 3'h0, pose_m.upright, pose_m.face});
    flag_m = 1'b0;
  endtask : rds

  // Model of an accepted pose: each rise of the flag must give one timer-clear pulse.
  task automatic hit(input ods_pose_t p);
    pose_m = p;
    if (!flag_m) rises++;
    flag_m = 1'b1;
  endtask : hit

  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge sys_clk);
      #1 odr_tick = 1'b1;
      @(posedge sys_clk);
      #1 odr_tick = 1'b0;
    end
  endtask : ticks

  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    cycles++;
    if (tclr_o === 1'b1) clr_seen++;
    if (cycles == 4000) begin
      err_total++;
      summarize();
    end
  end

  initial begin
    {rst_b, odr_tick, over_range, active_mode, soft_reset, flag_m, en_m, trig} = '0;
    ce = 1'b1;
    raw_pose = ODS_POSE_RST;
    pose_m = ODS_POSE_RST;
    dbc = 8'h00;
    void'($urandom(90));
    repeat (12) @(posedge sys_clk);
    #1 rst_b = 1'b1;
    rds();
    acc(1'b0, ODS_ADDR_SETUP, ODS_SETUP_RST);
    acc(1'b0, 8'h30, 8'h00);
    acc(1'b1, ODS_ADDR_STATUS, 8'hFF);
    rds();
    dbc = 8'h02 + 8'($urandom % 3);
    active_mode = 1'b1;
    acc(1'b1, ODS_ADDR_SETUP, 8'hC0);
    acc(1'b0, ODS_ADDR_SETUP, 8'hC0);
    for (int i = 1; i <= 4; i++) begin
      raw_pose = {1'($urandom), 2'(i), 1'($urandom)};
      ticks(dbc);
      if (i % 2) rds();
      ticks(2);
      hit(raw_pose);
      if (i % 2 == 0) rds();
    end
    rds();
    over_range = 1'b1;
    raw_pose = ods_pose_t'(~pose_m);
    ticks(dbc + 2);
    rds();
    acc(1'b1, ODS_ADDR_SETUP, 8'h80);
    over_range = 1'b0;
    ticks(dbc + 2);
    rds();
    acc(1'b1, ODS_ADDR_SETUP, 8'h40);
    acc(1'b0, ODS_ADDR_SETUP, 8'h40);
    ticks(2);
    hit(raw_pose);
    rds();
    raw_pose = ods_pose_t'(~pose_m);
    ce = 1'b0;
    ticks(dbc + 2);
    ce = 1'b1;
    rds();
    @(posedge sys_clk);
    #1 soft_reset = 1'b1;
    @(posedge sys_clk);
    #1 soft_reset = 1'b0;
    pose_m = ODS_POSE_RST;
    en_m = 1'b0;
    rds();
    acc(1'b0, ODS_ADDR_SETUP, ODS_SETUP_RST);
    active_mode = 1'b0;
    @(posedge sys_clk);
    #1 trig = 1'b1;
    raw_pose = ODS_POSE_RST;
    acc(1'b1, ODS_ADDR_SETUP, 8'hC0);
    ticks(dbc + 2);
    hit(ODS_POSE_RST);
    rds();
    check(8'(clr_seen), 8'(rises));
    summarize();
  end
endmodule : test_ods_status
